/* File: dv/qtimer_props.sv */
// Purpose: port checker for the timer channel
// Assumes: one clock, nrst synchronous and active low
// Notes:   bound to every timer instance
`timescale 1ns/10ps
`default_nettype none
module qtimer_props (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        ce,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic [31:0] avs_readdata,
	input wire logic        timer_out_pin_o,
	input wire logic        timer_out_pin_oe,
	input wire logic        irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// any request on the bus
	wire logic rq = avs_read | avs_write;
	// reset leaves the bus closed and the pulse low
	property p_rst; $rose(nrst) |-> avs_waitrequest && !irq
		&& !timer_out_pin_o; endproperty
	a_rst: assert property (p_rst) else $error("dirty reset");
	// one wait cycle, one answer cycle, then closed again
	property p_idle; ce && !rq |=> avs_waitrequest; endproperty
	a_idle: assert property (p_idle) else $error("open idle");
	property p_ans; ce && rq && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_one; ce && !avs_waitrequest |=> avs_waitrequest; endproperty
	a_one: assert property (p_one) else $error("long answer");
	// read data only move when a read is latched
	property p_hold; !(ce && avs_read && avs_waitrequest)
		|=> $stable(avs_readdata); endproperty
	a_hold: assert property (p_hold) else $error("data moved");
	// the terminal interrupt ends the pulse in the same cycle
	property p_end; timer_out_pin_oe && irq |-> !timer_out_pin_o;
	endproperty
	a_end: assert property (p_end) else $error("pulse outlives irq");
	// the pin turns to an output only through a register write
	property p_oe; $changed(timer_out_pin_oe)
		|-> $past(avs_write) || $past(avs_write, 2); endproperty
	a_oe: assert property (p_oe) else $error("pin role moved");
	// a low enable freezes irq, the out pin level and waitrequest
	property p_frz; !ce |=> $stable({irq, timer_out_pin_o, avs_waitrequest});
	endproperty
	a_frz: assert property (p_frz) else $error("ran while frozen");
	c_irq: cover property (irq);
	c_pulse: cover property ($fell(timer_out_pin_o));
	c_read: cover property (avs_read && !avs_waitrequest);
endmodule // qtimer_props
bind quadrature_and_oneshot_timer qtimer_props u_props (.clk(clk),
	.nrst(nrst), .ce(ce), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
	.timer_out_pin_o(timer_out_pin_o), .timer_out_pin_oe(timer_out_pin_oe),
	.irq(irq));
`default_nettype wire

/* File: dv/quad_encoder.sv */
// Purpose: two-phase encoder on the channel pins
// Assumes: the bench commands steps, edges just after a rising clk edge
// Notes:   lines hold their level between steps, as a shaft does
`timescale 1ns/10ps
`default_nettype none
module quad_encoder (
	input  wire logic clk,
	output logic      phase_a,
	output logic      phase_b
);
	logic [1:0] pos = 2'h0;
	// up order of {a,b} is 01,11,10,00: a rises while b is high
	assign phase_a = pos[0] ^ pos[1];
	assign phase_b = !pos[1];
	// gap sets the pace: small is a fast shaft, large a slow one
	task automatic go(bit up, int n, int gap);
		repeat (n) begin
			repeat (gap) @(posedge clk);
			pos <= up ? pos + 2'h1 : pos - 2'h1;
		end
	endtask
endmodule // quad_encoder
`default_nettype wire

/* File: dv/tb_quadrature_and_oneshot_timer.sv */
// Purpose: self-checking bench for the timer channel
// Assumes: encoder model on the pins, bus tasks on the registers
// Notes:   reads are checked from a queue by a monitor process
`timescale 1ns/10ps
`default_nettype none
module tb_quadrature_and_oneshot_timer;
	logic        clk = 0, nrst = 0, ce = 1, rd = 0, wr = 0;
	logic        ovf = 0, sub = 0, wreq, out_o, oe, irq, ea, eb;
	logic        wreq0, out0, oe0, irq0;
	logic [31:0] rdat0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wd = 32'h0, n, rdat, exq[$];
	integer      seed = 32'h9829D68A;
	int          fails = 0, checks_done = 0, irqs = 0, w;
	int          irqs0 = 0, pinless = 0;
	int          per[4] = '{1, 8, 32, 64};
	always #5 clk = ~clk;
	always @(posedge clk) sub <= !sub;
	quad_encoder enc (.clk(clk), .phase_a(ea), .phase_b(eb));
	// the out pin wire follows the channel while it drives it
	quadrature_and_oneshot_timer dut (.clk(clk), .nrst(nrst), .ce(ce),
		.avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat),
		.avs_waitrequest(wreq), .timer_in_pin(ea),
		.timer_out_pin_i(oe ? out_o : eb), .timer_out_pin_o(out_o),
		.timer_out_pin_oe(oe), .sub_clk_tick(sub), .ovf_trig(ovf),
		.irq(irq));
	// pinless channel on the same bus: its pins must have no effect
	quadrature_and_oneshot_timer #(.HAS_PINS(1'b0)) dut0 (.clk(clk),
		.nrst(nrst), .ce(ce), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF),
		.avs_readdata(rdat0), .avs_waitrequest(wreq0),
		.timer_in_pin(ea), .timer_out_pin_i(eb), .timer_out_pin_o(out0),
		.timer_out_pin_oe(oe0), .sub_clk_tick(sub), .ovf_trig(ovf),
		.irq(irq0));
	task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s exp %h seen %h", s, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// a used-up wait bound ends the run as a failure
	task automatic lim(int k, int m);
		if (k >= m) begin
			fails++;
			summarize();
		end
	endtask
	// hold the request until waitrequest is seen low, then release
	task automatic bus(logic [3:0] a, logic [31:0] d, bit r);
		int k;
		k = 0;
		@(posedge clk);
		adr <= a;
		wd <= d;
		rd <= r;
		wr <= !r;
		do begin
			@(posedge clk);
			k++;
		end while (wreq && k < 40);
		rd <= 0;
		wr <= 0;
		lim(k, 40);
	endtask
	task automatic wrt(logic [3:0] a, logic [31:0] d);
		bus(a, d, 0);
	endtask
	// the expected word is queued before the read goes out
	task automatic rdx(logic [3:0] a, logic [31:0] e);
		exq.push_back(e);
		bus(a, 32'h0, 1);
	endtask
	// pulse width on the out pin, in clock cycles
	task automatic pw(output int c);
		int k;
		k = 0;
		c = 0;
		while (out_o !== 1'b1 && k < 400) begin
			@(posedge clk);
			k++;
		end
		while (out_o === 1'b1 && c < 900) begin
			@(posedge clk);
			c++;
		end
		lim(k, 400);
	endtask
	// takes the oldest note whenever read data are taken
	always @(posedge clk) begin
		if (rd && !wreq && exq.size() > 0)
			chk("readdata", rdat, exq.pop_front());
		if (irq === 1'b1)
			irqs++;
		if (irq0 === 1'b1)
			irqs0++;
		if (nrst && {oe0, out0} !== 2'b00)
			pinless++;
	end
	initial begin
		repeat (60000) @(posedge clk);
		fails++;
		summarize();
	end
	// settle before each read after encoder steps: synchroniser plus edge detector lag
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1;
		repeat (2) @(posedge clk);
		rdx(4'h4, 32'h0);
		n = $random(seed) & 32'h7FFF | 32'h100;
		wrt(4'h0, n);
		rdx(4'h0, n);
		ce <= 0;
		@(posedge clk) ce <= 1;
		$display("load test done");
		wrt(4'h4, 32'h1);
		enc.go(1, 4, 3);
		enc.go(0, 8, 9);
		repeat (6) @(posedge clk);
		rdx(4'h0, n - 1);
		wrt(4'h4, 32'h5);
		enc.go(1, 6, 3);
		enc.go(0, 3, 3);
		repeat (6) @(posedge clk);
		rdx(4'h0, n + 2);
		wrt(4'h4, 32'h4);
		enc.go(1, 4, 3);
		repeat (6) @(posedge clk);
		rdx(4'h0, n + 2);
		chk("oe", oe, 0);
		$display("count test done");
		wrt(4'h0, 32'h2);
		wrt(4'h4, 32'h5);
		wrt(4'h0, 32'h5);
		rdx(4'h0, 32'h2);
		enc.go(0, 3, 3);
		repeat (6) @(posedge clk);
		rdx(4'h0, 32'h5);
		wrt(4'h4, 32'hD);
		enc.go(0, 6, 3);
		repeat (6) @(posedge clk);
		rdx(4'h0, 32'hFFFF);
		enc.go(1, 1, 3);
		repeat (6) @(posedge clk);
		rdx(4'h0, 32'h0);
		chk("irqs", irqs, 3);
		$display("wrap test done");
		wrt(4'h4, 32'h0);
		wrt(4'h0, 32'h5);
		foreach (per[s]) begin
			wrt(4'h4, 32'h13 | s << 5);
			fork
				pw(w);
				wrt(4'h8, 32'h1);
			join
			chk("width", w > 4 * per[s] && w <= 5 * per[s], 1);
		end
		chk("oe", oe, 1);
		rdx(4'h0, 32'hFFFF);
		rdx(4'hC, 32'h0);
		wrt(4'h4, 32'h113);
		fork
			pw(w);
			begin
				ovf <= 1;
				@(posedge clk) ovf <= 0;
				@(posedge clk) ovf <= 1;
				@(posedge clk) ovf <= 0;
			end
		join
		chk("retrigger", w, 7);
		wrt(4'h4, 32'h93);
		fork
			pw(w);
			enc.go(1, 2, 3);
		join
		chk("pin start", w, 5);
		wrt(4'h0, 32'hC8);
		wrt(4'h4, 32'h13);
		fork
			pw(w);
			begin
				wrt(4'h8, 32'h1);
				wrt(4'h4, 32'h12);
			end
		join
		chk("stop", w < 20, 1);
		chk("irqs", irqs, 9);
		$display("one-shot test done");
		chk("pinless pin", pinless, 0);
		chk("pinless irqs", irqs0, 5);
		chk("notes left", exq.size(), 0);
		summarize();
	end
endmodule // tb_quadrature_and_oneshot_timer
`default_nettype wire

/* File: hdl/pin_sync.sv */
// Purpose: two-stage synchroniser with edge detection for pin inputs
// Assumes: pins may change at any time relative to clk
// Notes:   rise and fall are one-cycle pulses on the synchronised level
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] pins,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] sync;
	logic [WIDTH-1:0] prev;

	// meta is read by sync alone, so a metastable sample never fans out
	always_ff @(posedge clk) begin
		if (!nrst) begin
			meta <= '0;
			sync <= '0;
			prev <= '0;
		end else if (ce) begin
			meta <= pins;
			sync <= meta;
			prev <= sync;
		end
	end

	// one pulse per settled edge
	assign level = sync;
	assign rise  = sync & ~prev & {WIDTH{ce}};
	assign fall  = ~sync & prev & {WIDTH{ce}};
endmodule // pin_sync
`default_nettype wire

/* File: hdl/qtimer_map.svh */
// Purpose: register offsets, field positions, reset values and counts
// Assumes: 32-bit Avalon-MM word registers, byte addressed
// Notes:   included by bare name, definitions only
`ifndef QTIMER_MAP_SVH
`define QTIMER_MAP_SVH

`define QT_ADDR_W        4
`define QT_OFF_TIMER     4'h0
`define QT_OFF_CTRL      4'h4
`define QT_OFF_START     4'h8
`define QT_OFF_STATUS    4'hC

`define QT_TMR_WIDTH     16
`define QT_CTRL_WIDTH    9
`define QT_CTRL_RESET    9'h000
`define QT_TIMER_RESET   16'h0000
`define QT_UNDEF_READ    16'hFFFF

`define QT_START_BIT     0
`define QT_STAT_RUN      0
`define QT_STAT_PULSE    1
`define QT_STAT_IN       2
`define QT_STAT_OUT      3

`define QT_PRE_W         5
`define QT_DIV8_MASK     5'h07
`define QT_DIV32_LAST    5'h1F

`endif

/* File: hdl/qtimer_pkg.sv */
// Purpose: shared types of the quadrature and one-shot timer
// Assumes: nothing beyond SystemVerilog packed types
// Notes:   offsets and counts live in qtimer_map.svh
`default_nettype none
package qtimer_pkg;

	// control register layout, msb first
	typedef struct packed {
		logic       ovf_trig_en;
		logic       ext_trig_en;
		logic [1:0] clk_sel;
		logic       pulse_en;
		logic       free_run;
		logic       mul4;
		logic       one_shot;
		logic       count_start;
	} ctrl_t;

	// count source taps for one-shot mode
	typedef enum logic [1:0] {
		SRC_UNDIVIDED,
		SRC_DIV8,
		SRC_DIV32,
		SRC_SUB_DIV32
	} clk_src_t;

	// one-shot sequencer
	typedef enum logic {
		OS_IDLE,
		OS_RUN
	} os_state_t;

endpackage
`default_nettype wire

/* File: hdl/quadrature_and_oneshot_timer.sv */
// Purpose: 16-bit timer channel, two-phase event count and one-shot modes
// Assumes: Avalon-MM slave with waitrequest, clk 100 MHz, sync low reset
// Notes:   pin counting, the pin trigger and pin outputs are gated off when HAS_PINS is 0
// Contract
// - two-phase pins set count direction
// - overflow or underflow reloads counter
// - free-run wraps instead of reloading
// - up divides FFFF-n+1, down n+1
// - event count runs while start flag set
// - interrupt on overflow or underflow
// - both pins are two-phase inputs
// - timer read returns live count
// - write while stopped loads reload and counter
// - write while running loads reload only
// - normal: out high, in edges count
// - times four: in rises, all edges up
// - times four: in falls, all edges down
// - one-shot counts selected tap, n periods
// - at zero reload then stop
// - trigger while counting reloads and restarts
// - start by pin, overflow or software
// - clearing start flag stops one-shot
// - one-shot interrupt when count hits zero
// - one-shot read returns undefined value
// - in pin triggers, out pin pulses
// - pinless channels lose all pin functions except the status pin levels
`timescale 1ns/10ps
`default_nettype none
`include "qtimer_map.svh"
module quadrature_and_oneshot_timer #(
	parameter int WIDTH    = `QT_TMR_WIDTH,
	parameter bit HAS_PINS = 1'b1
) (
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire logic                  ce,
	input  wire logic [`QT_ADDR_W-1:0] avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	input  wire logic [3:0]            avs_byteenable,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest,
	input  wire logic                  timer_in_pin,
	input  wire logic                  timer_out_pin_i,
	output logic                       timer_out_pin_o,
	output logic                       timer_out_pin_oe,
	input  wire logic                  sub_clk_tick,
	input  wire logic                  ovf_trig,
	output logic                       irq
);
	localparam logic [WIDTH-1:0] ALL_ONES = {WIDTH{1'b1}};
	localparam logic [WIDTH-1:0] ONE      = {{(WIDTH-1){1'b0}}, 1'b1};

	qtimer_pkg::ctrl_t     ctrl;
	qtimer_pkg::os_state_t os_state;
	logic [WIDTH-1:0]      counter;
	logic [WIDTH-1:0]      reload;
	logic [WIDTH-1:0]      next_reload;
	logic [WIDTH-1:0]      merged_timer;
	logic [`QT_PRE_W-1:0]  pre_cnt;
	logic [`QT_PRE_W-1:0]  sub_cnt;
	logic [1:0]            pin_level;
	logic [1:0]            pin_rise;
	logic [1:0]            pin_fall;
	logic                  take;
	logic                  wr_timer;
	logic                  wr_ctrl;
	logic                  sw_start;
	logic                  tick;
	logic                  step;
	logic                  step_up;
	logic                  wrap_evt;
	logic                  trigger;
	logic                  zero_evt;
	logic                  running;

	// merge written bytes into a value, honouring byte enables
	function automatic logic [WIDTH-1:0] merge_bytes(
		input logic [WIDTH-1:0] old,
		input logic [31:0]      wd,
		input logic [3:0]       be
	);
		logic [WIDTH-1:0] res;
		res = old;
		for (int b = 0; b < WIDTH / 8; b++) begin
			if (be[b]) begin
				res[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// direction of a times-four step; in_edge says which pin moved
	function automatic logic quad_up(
		input logic in_edge,
		input logic in_lvl,
		input logic out_lvl
	);
		if (in_edge) begin
			return in_lvl == out_lvl;
		end
		return out_lvl != in_lvl;
	endfunction

	// both pins pass one synchroniser; index 0 in pin, 1 out pin
	pin_sync #(
		.WIDTH (2)
	) u_pin_sync (
		.clk   (clk),
		.nrst  (nrst),
		.ce    (ce),
		.pins  ({timer_out_pin_i, timer_in_pin}),
		.level (pin_level),
		.rise  (pin_rise),
		.fall  (pin_fall)
	);

	// a request is taken in the cycle waitrequest stands low
	assign take     = (avs_read | avs_write) & ~avs_waitrequest & ce;
	assign wr_timer = take & avs_write & (avs_address == `QT_OFF_TIMER);
	assign wr_ctrl  = take & avs_write & (avs_address == `QT_OFF_CTRL);
	assign sw_start = take & avs_write & (avs_address == `QT_OFF_START)
		& avs_byteenable[0] & avs_writedata[`QT_START_BIT];

	// one wait cycle, then one ready cycle per transfer
	always_ff @(posedge clk) begin
		if (!nrst) begin
			avs_waitrequest <= 1'b1;
		end else if (ce) begin
			if ((avs_read | avs_write) & avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
			end else begin
				avs_waitrequest <= 1'b1;
			end
		end
	end

	// read data is latched in the wait cycle and stands while ready
	always_ff @(posedge clk) begin
		if (!nrst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (ce && avs_read && avs_waitrequest) begin
			avs_readdata <= 32'h0000_0000;
			case (avs_address)
				`QT_OFF_TIMER: begin
					if (ctrl.one_shot) begin
						avs_readdata[WIDTH-1:0] <= `QT_UNDEF_READ;
					end else begin
						avs_readdata[WIDTH-1:0] <= counter;
					end
				end
				`QT_OFF_CTRL: begin
					avs_readdata[`QT_CTRL_WIDTH-1:0] <= ctrl;
				end
				`QT_OFF_STATUS: begin
					avs_readdata[`QT_STAT_RUN]   <= running;
					avs_readdata[`QT_STAT_PULSE] <= timer_out_pin_o;
					avs_readdata[`QT_STAT_IN]    <= pin_level[0];
					avs_readdata[`QT_STAT_OUT]   <= pin_level[1];
				end
				default: begin
					avs_readdata <= 32'h0000_0000;
				end
			endcase
		end
	end

	// control register; the start pulse register reads as zero
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctrl <= `QT_CTRL_RESET;
		end else if (wr_ctrl) begin
			if (avs_byteenable[0]) begin
				ctrl[7:0] <= avs_writedata[7:0];
			end
			if (avs_byteenable[1]) begin
				ctrl[8] <= avs_writedata[8];
			end
		end
	end

	// reload register always takes a write, running or not
	assign merged_timer = merge_bytes(counter, avs_writedata, avs_byteenable);
	assign next_reload  = wr_timer
		? merge_bytes(reload, avs_writedata, avs_byteenable) : reload;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			reload <= `QT_TIMER_RESET;
		end else if (ce) begin
			reload <= next_reload;
		end
	end

	// free prescaler for the divided taps of the system clock
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pre_cnt <= '0;
		end else if (ce) begin
			pre_cnt <= pre_cnt + 5'h01;
		end
	end

	// sub-clock ticks are divided by 32 in the same way
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sub_cnt <= '0;
		end else if (ce && sub_clk_tick) begin
			sub_cnt <= sub_cnt + 5'h01;
		end
	end

	// count source choice for one-shot mode
	always_comb begin
		tick = 1'b0;
		case (qtimer_pkg::clk_src_t'(ctrl.clk_sel))
			qtimer_pkg::SRC_UNDIVIDED: tick = ce;
			qtimer_pkg::SRC_DIV8:
				tick = ce & ((pre_cnt & `QT_DIV8_MASK) == `QT_DIV8_MASK);
			qtimer_pkg::SRC_DIV32:
				tick = ce & (pre_cnt == `QT_DIV32_LAST);
			qtimer_pkg::SRC_SUB_DIV32:
				tick = ce & sub_clk_tick & (sub_cnt == `QT_DIV32_LAST);
			default: tick = 1'b0;
		endcase
	end

	// two-phase decode; pinless channels never see a step
	always_comb begin
		step    = 1'b0;
		step_up = 1'b0;
		if (HAS_PINS && !ctrl.one_shot && ctrl.count_start) begin
			if (ctrl.mul4) begin
				// a step on both pins at once is invalid and dropped
				if ((pin_rise[0] | pin_fall[0]) ^
					(pin_rise[1] | pin_fall[1])) begin
					step    = 1'b1;
					step_up = quad_up(pin_rise[0] | pin_fall[0],
						pin_level[0], pin_level[1]);
				end
			end else if (pin_level[1]) begin
				step    = pin_rise[0] | pin_fall[0];
				step_up = pin_rise[0];
			end
		end
	end

	// wrap happens when a step passes the end of the range
	assign wrap_evt = step & (step_up ? (counter == ALL_ONES)
		: (counter == '0));

	// one-shot start sources, all gated by the count start flag
	assign trigger = ctrl.one_shot & ctrl.count_start & (sw_start
		| (ctrl.ovf_trig_en & ovf_trig & ce)
		| (HAS_PINS & ctrl.ext_trig_en & pin_rise[0]));

	assign running = (os_state == qtimer_pkg::OS_RUN);

	// a set value of 0 or 1 ends on the first tick
	assign zero_evt = running & ctrl.count_start & tick
		& (counter <= ONE);

	// one-shot sequencer
	always_ff @(posedge clk) begin
		if (!nrst) begin
			os_state <= qtimer_pkg::OS_IDLE;
		end else if (ce) begin
			case (os_state)
				qtimer_pkg::OS_IDLE: begin
					if (trigger) begin
						os_state <= qtimer_pkg::OS_RUN;
					end
				end
				qtimer_pkg::OS_RUN: begin
					if (!ctrl.one_shot || !ctrl.count_start) begin
						os_state <= qtimer_pkg::OS_IDLE;
					end else if (trigger) begin
						os_state <= qtimer_pkg::OS_RUN;
					end else if (zero_evt) begin
						os_state <= qtimer_pkg::OS_IDLE;
					end
				end
				default: begin
					os_state <= qtimer_pkg::OS_IDLE;
				end
			endcase
		end
	end

	// counter: trigger, write, count step, in that priority
	always_ff @(posedge clk) begin
		if (!nrst) begin
			counter <= `QT_TIMER_RESET;
		end else if (ce) begin
			if (ctrl.one_shot) begin
				if (trigger) begin
					counter <= next_reload;
				end else if (wr_timer && !running) begin
					counter <= merged_timer;
				end else if (zero_evt) begin
					counter <= reload;
				end else if (running && ctrl.count_start && tick) begin
					counter <= counter - ONE;
				end
			end else begin
				if (wr_timer && !ctrl.count_start) begin
					counter <= merged_timer;
				end else if (wrap_evt && !ctrl.free_run) begin
					counter <= reload;
				end else if (step && step_up) begin
					counter <= counter + ONE;
				end else if (step) begin
					counter <= counter - ONE;
				end
			end
		end
	end

	// interrupt request is a one-cycle pulse per event
	always_ff @(posedge clk) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else if (ce) begin
			// a restart in the terminal cycle means zero was never reached
			irq <= wrap_evt | (zero_evt & ~trigger);
		end
	end

	// out pin is driven only as the one-shot pulse output
	always_ff @(posedge clk) begin
		if (!nrst) begin
			timer_out_pin_oe <= 1'b0;
		end else if (ce) begin
			timer_out_pin_oe <= HAS_PINS & ctrl.one_shot
				& ctrl.pulse_en;
		end
	end

	// pulse level follows the next sequencer state, so it lines up
	// with the counter load and drops with the terminal reload
	always_ff @(posedge clk) begin
		if (!nrst) begin
			timer_out_pin_o <= 1'b0;
		end else if (ce) begin
			if (!HAS_PINS || !ctrl.one_shot || !ctrl.pulse_en) begin
				timer_out_pin_o <= 1'b0;
			end else if (trigger) begin
				timer_out_pin_o <= 1'b1;
			end else if (!ctrl.count_start || zero_evt) begin
				timer_out_pin_o <= 1'b0;
			end else begin
				timer_out_pin_o <= running;
			end
		end
	end

endmodule // quadrature_and_oneshot_timer
`default_nettype wire
